/* include/earth_fault_pkg.sv */
package earth_fault_pkg;
  // clock and time base
  localparam int CLK_HZ              = 40_000_000;
  localparam int TICK_MS             = 1;
  localparam int MS_CYCLES_DEF       = CLK_HZ / 1000 * TICK_MS;
  localparam int FORCE_TIMEOUT_MIN   = 5;
  localparam int FORCE_TIMEOUT_MS    = FORCE_TIMEOUT_MIN * 60 * 1000;
  localparam int ATTEN_H3_DB         = 60;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_PICKUP  = 8'h04;
  localparam logic [7:0] OFS_UOPICK  = 8'h08;
  localparam logic [7:0] OFS_OFFSET  = 8'h0c;
  localparam logic [7:0] OFS_HALF    = 8'h10;
  localparam logic [7:0] OFS_OPTIME  = 8'h14;
  localparam logic [7:0] OFS_KMULT   = 8'h18;
  localparam logic [7:0] OFS_INTRMT  = 8'h1c;
  localparam logic [7:0] OFS_STATUS  = 8'h20;
  localparam logic [7:0] OFS_COUNT   = 8'h24;
  localparam logic [7:0] OFS_RSEL    = 8'h28;
  localparam logic [7:0] OFS_REC0    = 8'h2c;
  localparam logic [7:0] OFS_REC1    = 8'h30;
  localparam logic [7:0] OFS_REC2    = 8'h34;
  localparam logic [7:0] OFS_REC3    = 8'h38;
  localparam logic [7:0] OFS_SELVAL  = 8'h3c;
  localparam logic [7:0] OFS_CURVE   = 8'h40;

  // control field positions
  localparam int CTRL_MODE_LSB       = 0;
  localparam int CTRL_KIND_BIT       = 2;
  localparam int CTRL_INPUT_LSB      = 3;
  localparam int CTRL_SUBCTL_LSB     = 5;
  localparam int CTRL_SUBIDX_LSB     = 7;
  localparam int CTRL_FORCE_BIT      = 10;

  // reset values
  localparam logic [15:0] PICKUP_RST = 16'h0100;
  localparam logic [7:0]  UOPICK_RST = 8'h0a;
  localparam logic [7:0]  HALF_RST   = 8'd88;
  localparam logic [15:0] OPTIME_RST = 16'h0064;
  localparam logic [15:0] KMULT_RST  = 16'h0100;
  localparam logic [15:0] INTRMT_RST = 16'h0000;
  localparam logic [7:0]  CURVE_RST  = 8'h00;
  localparam logic [7:0]  PCT_FULL   = 8'd100;
  localparam logic [8:0]  QUARTER    = 9'sd90;
  localparam int          NREC       = 8;

  typedef enum logic [1:0] {MODE_RES_CAP_CHARACTERISTIC = 2'h0, MODE_SECTOR = 2'h1, MODE_UNDIR = 2'h2} mode_t;
  typedef enum logic [1:0] {IN_MEAS = 2'h0, IN_CALC = 2'h1, IN_PEAK = 2'h2} input_sel_t;
  typedef enum logic [1:0] {SUB_RES = 2'h0, SUB_CAP = 2'h1, SUB_DI = 2'h2, SUB_VI = 2'h3} subctl_t;
  typedef enum logic [1:0] {USE_NONE = 2'h0, USE_RES = 2'h1, USE_CAP = 2'h2} submode_status_t;

  // fundamental phasors and derived quantities from the front end
  typedef struct packed {
    logic signed [15:0]           io_re;
    logic signed [15:0]           io_im;
    logic signed [15:0]           pk_re;
    logic signed [15:0]           pk_im;
    logic signed [2:0][1:0][15:0] phase;
    logic signed [8:0]            angle;
    logic [7:0]                   uo_pct;
    logic [15:0]                  res_part;
    logic [15:0]                  cap_part;
  } meas_t;

  typedef struct packed {
    logic [3:0]  family;
    logic [3:0]  curve_type;
    logic [15:0] k_mult;
    logic [15:0] current;
  } inv_req_t;

  typedef struct packed {
    logic [63:0]       stamp;
    logic [15:0]       cur;
    logic [15:0]       comp;
    logic [7:0]        elapsed_delay_percent;
    logic signed [8:0] angle;
    logic [7:0]        uo;
    logic [2:0]        grp;
  } fault_rec_t;
endpackage

/* hw/earth_fault_stage_logic.sv */
// Notes on behaviour
// - start when fundamental magnitude of selected residual current, or in resistive/capacitive mode its active component, exceeds pick-up
// - trip once start has lasted longer than the operation delay
// - restart within intermittent time keeps the accumulated delay count
// - comparison uses fundamental phasors, third harmonic attenuated over 60 dB
// - input: measured, sum of three phases, or peak on first stage only
// - mode picks resistive/capacitive, sector or undirectional characteristic
// - directional modes rotate characteristic by max torque angle in degrees
// - sector mode trips within half-sector each side of offset, default 88
// - submode fixed resistive or capacitive, or chosen by digital/virtual input
// - report active submode and only the matching current component
// - hold residual voltage pick-up and report measured voltage in percent
// - definite time uses operation time, inverse uses curve select and multiplier
// - keep eight latest fault records with time stamp, current, delay
// - record elapsed delay in percent, 100 means tripped
// - record max current, angle, max residual voltage, setting group 1-4
// - undirectional mode ignores angle and voltage, checks amplitude only
// - force flag clears itself after five minutes
`timescale 1ns/1ps
`default_nettype none
module earth_fault_stage_logic
  import earth_fault_pkg::*;
#(
  parameter int MS_CYCLES   = MS_CYCLES_DEF,    // clock cycles per ms tick
  parameter int FORCE_MS    = FORCE_TIMEOUT_MS, // force timeout in ms
  parameter bit FIRST_STAGE = 1'b1              // peak input allowed
)(
  input  wire logic        clock_i,           // 40 MHz clock
  input  wire logic        reset_n_i,         // async reset, active low
  input  wire logic        wb_cyc_i,          // wishbone cycle
  input  wire logic        wb_stb_i,          // wishbone strobe
  input  wire logic        wb_we_i,           // wishbone write
  input  wire logic [7:0]  wb_adr_i,          // byte address
  input  wire logic [3:0]  wb_sel_i,          // byte lanes
  input  wire logic [31:0] wb_dat_i,          // write data
  output logic      [31:0] wb_dat_o,          // read data
  output logic             wb_ack_o,          // acknowledge
  input  wire meas_t       meas_i,            // front end quantities
  input  wire logic [63:0] stamp_i,           // date and time of day
  input  wire logic [1:0]  set_group_i,       // active group minus one
  input  wire logic [7:0]  digital_in_i,      // digital input pins
  input  wire logic [7:0]  virtual_in_i,      // virtual inputs
  input  wire logic [19:0] inverse_time_ms_i, // external curve result
  output inv_req_t         inv_req_o,         // external curve request
  output logic             start_o,           // stage started
  output logic             trip_o             // stage tripped
);

  typedef enum logic [2:0] {ST_IDLE = 3'b001, ST_RUN = 3'b010, ST_HOLD = 3'b100} state_t;

  function automatic logic [15:0] mag(input logic signed [17:0] re, input logic signed [17:0] im);
    logic [17:0] a;
    logic [17:0] b;
    logic [17:0] m;
    a = re[17] ? 18'(-re) : 18'(re);
    b = im[17] ? 18'(-im) : 18'(im);
    m = (a > b) ? 18'(a + (b >> 1)) : 18'(b + (a >> 1));
    return (m > 18'h0ffff) ? 16'hffff : m[15:0];
  endfunction

  function automatic logic [8:0] absdeg(input logic signed [10:0] d);
    logic signed [10:0] w;
    w = d;
    if (w > 11'sd180) begin
      w = 11'(w - 11'sd360);
    end
    if (w < -11'sd180) begin
      w = 11'(w + 11'sd360);
    end
    return w[10] ? 9'(-w) : 9'(w);
  endfunction

  function automatic logic [31:0] wmask(input logic [31:0] old, input logic [31:0] dat, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = dat[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // registers
  logic [31:0]        ctrl_r;
  logic [15:0]        pickup_r;
  logic [7:0]         uopick_r;
  logic signed [8:0]  offset_r;
  logic [7:0]         half_r;
  logic [15:0]        optime_r;
  logic [15:0]        kmult_r;
  logic [15:0]        intrmt_r;
  logic [7:0]         curve_r;
  logic [2:0]         rsel_r;
  logic [1:0]         forced_r;
  logic [15:0]        scnt_r;
  logic [15:0]        tcnt_r;
  logic [7:0]         di_meta_r;
  logic [7:0]         di_sync_r;
  logic [15:0]        pre_r;
  logic [19:0]        force_cnt_r;
  logic [19:0]        acc_r;
  logic [15:0]        int_cnt_r;
  state_t             state_r;
  logic               start_r;
  logic               trip_r;
  logic               tripped_r;
  logic [15:0]        max_cur_r;
  logic [15:0]        max_comp_r;
  logic [7:0]         max_uo_r;
  logic signed [8:0]  max_ang_r;
  fault_rec_t         rec_mem [NREC];
  logic [2:0]         wptr_r;

  // bus decode
  logic        wr;
  logic        rd_access;
  logic [31:0] wval;
  assign rd_access = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr        = rd_access & wb_we_i;

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= rd_access;
    end
  end

  // control fields
  mode_t      mode;
  input_sel_t in_sel;
  subctl_t    subctl;
  logic       inverse;
  logic       force_on;
  assign mode     = mode_t'(ctrl_r[CTRL_MODE_LSB +: 2]);
  assign inverse  = ctrl_r[CTRL_KIND_BIT];
  assign in_sel   = input_sel_t'(ctrl_r[CTRL_INPUT_LSB +: 2]);
  assign subctl   = subctl_t'(ctrl_r[CTRL_SUBCTL_LSB +: 2]);
  assign force_on = ctrl_r[CTRL_FORCE_BIT];

  // ms tick
  logic tick;
  assign tick = (pre_r == 16'(MS_CYCLES - 1));
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pre_r <= 16'h0000;
    end else begin
      pre_r <= tick ? 16'h0000 : 16'(pre_r + 16'h0001);
    end
  end

  // configuration writes; force auto-clear
  logic force_expire;
  assign force_expire = force_on & tick & (force_cnt_r >= 20'(FORCE_MS - 1));
  assign wval = wmask(32'h0000_0000, wb_dat_i, wb_sel_i);
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_r   <= 32'h0000_0000;
      pickup_r <= PICKUP_RST;
      uopick_r <= UOPICK_RST;
      offset_r <= 9'sd0;
      half_r   <= HALF_RST;
      optime_r <= OPTIME_RST;
      kmult_r  <= KMULT_RST;
      intrmt_r <= INTRMT_RST;
      curve_r  <= CURVE_RST;
      rsel_r   <= 3'h0;
    end else begin
      if (wr) begin
        unique case (wb_adr_i)
          OFS_CTRL:   ctrl_r   <= wmask(ctrl_r, wb_dat_i, wb_sel_i) & 32'h0000_07ff;
          OFS_PICKUP: pickup_r <= wval[15:0];
          OFS_UOPICK: uopick_r <= wval[7:0];
          OFS_OFFSET: offset_r <= wval[8:0];
          OFS_HALF:   half_r   <= wval[7:0];
          OFS_OPTIME: optime_r <= wval[15:0];
          OFS_KMULT:  kmult_r  <= wval[15:0];
          OFS_INTRMT: intrmt_r <= wval[15:0];
          OFS_CURVE:  curve_r  <= wval[7:0];
          OFS_RSEL:   rsel_r   <= wval[2:0];
          default: ;
        endcase
      end
      if (force_expire && !(wr && wb_adr_i == OFS_CTRL)) begin
        ctrl_r[CTRL_FORCE_BIT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      force_cnt_r <= 20'h00000;
    end else if (!force_on) begin
      force_cnt_r <= 20'h00000;
    end else if (tick) begin
      force_cnt_r <= 20'(force_cnt_r + 20'h00001);
    end
  end

  // forced status bits only take writes while force is on
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      forced_r <= 2'b00;
    end else if (!force_on) begin
      forced_r <= 2'b00;
    end else if (wr && wb_adr_i == OFS_STATUS && wb_sel_i[0]) begin
      forced_r <= wb_dat_i[1:0];
    end
  end

  // digital input pins are asynchronous
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      di_meta_r <= 8'h00;
      di_sync_r <= 8'h00;
    end else begin
      di_meta_r <= digital_in_i;
      di_sync_r <= di_meta_r;
    end
  end

  // input selection; front end phasors are already fundamental-only
  logic signed [17:0] calc_re;
  logic signed [17:0] calc_im;
  logic [15:0]        sel_mag;
  // a select of a packed array is unsigned, so restore the sign before widening
  assign calc_re = 18'(signed'(meas_i.phase[0][0])) + 18'(signed'(meas_i.phase[1][0]))
                 + 18'(signed'(meas_i.phase[2][0]));
  assign calc_im = 18'(signed'(meas_i.phase[0][1])) + 18'(signed'(meas_i.phase[1][1]))
                 + 18'(signed'(meas_i.phase[2][1]));
  always_comb begin
    unique case (in_sel)
      IN_CALC: sel_mag = mag(calc_re, calc_im);
      IN_PEAK: sel_mag = FIRST_STAGE ? mag(18'(meas_i.pk_re), 18'(meas_i.pk_im))
                                     : mag(18'(meas_i.io_re), 18'(meas_i.io_im));
      default: sel_mag = mag(18'(meas_i.io_re), 18'(meas_i.io_im));
    endcase
  end

  // submode and directional qualification
  logic            sub_cap;
  submode_status_t use_st;
  logic [15:0]     comp;
  logic [8:0]      dev;
  logic            dir_ok;
  logic [15:0]     cmp_val;
  logic            start_raw;
  always_comb begin
    unique case (subctl)
      SUB_RES: sub_cap = 1'b0;
      SUB_CAP: sub_cap = 1'b1;
      SUB_DI:  sub_cap = di_sync_r[ctrl_r[CTRL_SUBIDX_LSB +: 3]];
      default: sub_cap = virtual_in_i[ctrl_r[CTRL_SUBIDX_LSB +: 3]];
    endcase
  end
  assign use_st = (mode != MODE_RES_CAP_CHARACTERISTIC) ? USE_NONE : (sub_cap ? USE_CAP : USE_RES);
  assign comp   = sub_cap ? meas_i.cap_part : meas_i.res_part;
  always_comb begin
    // capacitive axis lies a quarter turn from the resistive one
    dev = absdeg(11'(meas_i.angle) - 11'(offset_r) - ((mode == MODE_RES_CAP_CHARACTERISTIC && sub_cap) ? 11'(QUARTER) : 11'sd0));
    unique case (mode)
      MODE_SECTOR: begin
        dir_ok  = (meas_i.uo_pct >= uopick_r) && (dev <= 9'(half_r));
        cmp_val = sel_mag;
      end
      MODE_RES_CAP_CHARACTERISTIC: begin
        dir_ok  = (meas_i.uo_pct >= uopick_r) && (dev < 9'(QUARTER));
        cmp_val = comp;
      end
      default: begin
        dir_ok  = 1'b1;
        cmp_val = sel_mag;
      end
    endcase
  end
  assign start_raw = dir_ok && (cmp_val > pickup_r);

  // delay target from definite setting or external inverse curve
  logic [19:0] target;
  assign target = inverse ? inverse_time_ms_i : 20'(optime_r);

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      inv_req_o <= '0;
    end else begin
      inv_req_o <= '{family: curve_r[3:0], curve_type: curve_r[7:4], k_mult: kmult_r, current: sel_mag};
    end
  end

  // stage sequencing
  logic fault_end;
  assign fault_end = (state_r == ST_RUN) && !start_raw;
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r   <= ST_IDLE;
      acc_r     <= 20'h00000;
      int_cnt_r <= 16'h0000;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          acc_r <= 20'h00000;
          if (start_raw) begin
            state_r <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (tick && acc_r != 20'hfffff) begin
            acc_r <= 20'(acc_r + 20'h00001);
          end
          int_cnt_r <= 16'h0000;
          if (!start_raw) begin
            state_r <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (start_raw) begin
            state_r <= ST_RUN;
          end else if (int_cnt_r >= intrmt_r) begin
            state_r <= ST_IDLE;
            acc_r   <= 20'h00000;
          end else if (tick) begin
            int_cnt_r <= 16'(int_cnt_r + 16'h0001);
          end
        end
      endcase
    end
  end

  logic trip_now;
  assign trip_now = (state_r == ST_RUN) && start_raw && (acc_r > target);
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      start_r <= 1'b0;
      trip_r  <= 1'b0;
      start_o <= 1'b0;
      trip_o  <= 1'b0;
      scnt_r  <= 16'h0000;
      tcnt_r  <= 16'h0000;
    end else begin
      start_r <= start_raw;
      trip_r  <= trip_now;
      start_o <= start_raw | forced_r[0];
      trip_o  <= trip_now | forced_r[1];
      // counts win over a clear in the same cycle
      if (start_raw && !start_r) begin
        scnt_r <= 16'(scnt_r + 16'h0001);
      end else if (wr && wb_adr_i == OFS_COUNT) begin
        scnt_r <= 16'h0000;
      end
      if (trip_now && !trip_r) begin
        tcnt_r <= 16'(tcnt_r + 16'h0001);
      end else if (wr && wb_adr_i == OFS_COUNT) begin
        tcnt_r <= 16'h0000;
      end
    end
  end

  // fault maxima, restarted each new start
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      max_cur_r  <= 16'h0000;
      max_comp_r <= 16'h0000;
      max_uo_r   <= 8'h00;
      max_ang_r  <= 9'sd0;
      tripped_r  <= 1'b0;
    end else if (start_raw && !start_r) begin
      max_cur_r  <= sel_mag;
      max_comp_r <= comp;
      max_uo_r   <= meas_i.uo_pct;
      max_ang_r  <= meas_i.angle;
      tripped_r  <= 1'b0;
    end else if (start_raw) begin
      if (sel_mag > max_cur_r) begin
        max_cur_r <= sel_mag;
        max_ang_r <= meas_i.angle;
      end
      if (comp > max_comp_r) begin
        max_comp_r <= comp;
      end
      if (meas_i.uo_pct > max_uo_r) begin
        max_uo_r <= meas_i.uo_pct;
      end
      tripped_r <= tripped_r | trip_now;
    end
  end

  // elapsed delay in percent, saturated at full
  logic [31:0] pct;
  logic [7:0]  elapsed_delay_percent;
  assign pct  = (target == 20'h00000) ? 32'(PCT_FULL) : 32'((32'(acc_r) * 32'd100) / 32'(target));
  assign elapsed_delay_percent = (tripped_r || pct >= 32'(PCT_FULL)) ? PCT_FULL : pct[7:0];

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wptr_r <= 3'h0;
    end else if (fault_end) begin
      wptr_r <= 3'(wptr_r + 3'h1);
    end
  end

  always_ff @(posedge clock_i) begin
    if (fault_end) begin
      rec_mem[wptr_r] <= '{stamp: stamp_i, cur: max_cur_r,
                           comp: (use_st == USE_NONE) ? 16'h0000 : max_comp_r,
                           elapsed_delay_percent: elapsed_delay_percent, angle: max_ang_r, uo: max_uo_r,
                           grp: 3'(set_group_i) + 3'h1};
    end
  end

  // read mux; record index 0 is the newest fault
  fault_rec_t rec;
  assign rec = rec_mem[3'(wptr_r - 3'h1 - rsel_r)];
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (rd_access && !wb_we_i) begin
      unique case (wb_adr_i)
        OFS_CTRL:   wb_dat_o <= ctrl_r;
        OFS_PICKUP: wb_dat_o <= 32'(pickup_r);
        OFS_UOPICK: wb_dat_o <= 32'(uopick_r);
        OFS_OFFSET: wb_dat_o <= 32'(unsigned'(offset_r));
        OFS_HALF:   wb_dat_o <= 32'(half_r);
        OFS_OPTIME: wb_dat_o <= 32'(optime_r);
        OFS_KMULT:  wb_dat_o <= 32'(kmult_r);
        OFS_INTRMT: wb_dat_o <= 32'(intrmt_r);
        OFS_STATUS: wb_dat_o <= {16'h0000, meas_i.uo_pct, 4'h0, use_st, trip_o, start_o};
        OFS_COUNT:  wb_dat_o <= {tcnt_r, scnt_r};
        OFS_RSEL:   wb_dat_o <= 32'(rsel_r);
        OFS_REC0:   wb_dat_o <= rec.stamp[31:0];
        OFS_REC1:   wb_dat_o <= rec.stamp[63:32];
        OFS_REC2:   wb_dat_o <= {rec.comp, rec.cur};
        OFS_REC3:   wb_dat_o <= {rec.grp, rec.uo, 4'h0, rec.angle, rec.elapsed_delay_percent};
        OFS_SELVAL: wb_dat_o <= 32'(sel_mag);
        OFS_CURVE:  wb_dat_o <= 32'(curve_r);
        default:    wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

endmodule
`default_nettype wire

/* testbench/earth_fault_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module earth_fault_chk
  import earth_fault_pkg::*;
(
  input wire logic        clock_i,   // clock
  input wire logic        reset_n_i, // reset
  input wire logic        wb_cyc_i,  // cycle
  input wire logic        wb_stb_i,  // strobe
  input wire logic        wb_we_i,   // write
  input wire logic [7:0]  wb_adr_i,  // address
  input wire logic [31:0] wb_dat_o,  // read data
  input wire logic        wb_ack_o,  // ack
  input wire meas_t       meas_i,    // front end
  input wire logic        start_o,   // start
  input wire logic        trip_o     // trip
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_rd(logic [7:0] a);
    s_req ##0 (!wb_we_i && wb_adr_i == a) ##1 wb_ack_o;
  endsequence
  a_ack_next_cycle: assert property (s_req |=> wb_ack_o) else $error("ack late");
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_status_bits: assert property (s_rd(OFS_STATUS) ##0 $stable({trip_o, start_o})
    |-> wb_dat_o[1:0] == {trip_o, start_o}) else $error("status bits wrong");
  a_status_uo: assert property (s_rd(OFS_STATUS) ##0 $stable(meas_i.uo_pct)
    |-> wb_dat_o[15:8] == meas_i.uo_pct) else $error("voltage percent wrong");
  a_submode_code: assert property (s_rd(OFS_STATUS) |-> wb_dat_o[3:2] != 2'h3)
    else $error("submode code bad");
  a_rec_group: assert property (s_rd(OFS_REC3) |-> wb_dat_o[31:29] inside {[3'h1:3'h4]})
    else $error("record group bad");
  a_rec_elapsed_delay_percent: assert property (s_rd(OFS_REC3) |-> wb_dat_o[7:0] <= PCT_FULL)
    else $error("record delay over full");
  a_unmapped_zero: assert property (s_rd(8'h44) |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
endmodule
bind earth_fault_stage_logic earth_fault_chk u_chk (
  .clock_i(clock_i), .reset_n_i(reset_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .meas_i(meas_i), .start_o(start_o), .trip_o(trip_o));
`default_nettype wire

/* testbench/front_end_model.sv */
`timescale 1ns/1ps
`default_nettype none
module front_end_model
  import earth_fault_pkg::*;
(
  input  wire logic        clock_i,  // clock
  input  wire logic [15:0] io_amp_i, // residual amplitude
  input  wire logic [15:0] ph_amp_i, // each phase component
  input  wire logic [7:0]  uo_i,     // residual voltage %
  output var meas_t        meas_o    // quantities to stage
);
  // fundamental phasors only, harmonics removed upstream
  always_ff @(posedge clock_i) begin
    meas_o          <= '0;
    meas_o.io_re    <= io_amp_i;
    meas_o.pk_re    <= io_amp_i;
    meas_o.phase    <= {6{ph_amp_i}}; // three phases summed by stage
    meas_o.uo_pct   <= uo_i;
    meas_o.res_part <= io_amp_i;
    meas_o.cap_part <= io_amp_i;
  end
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import earth_fault_pkg::*;
;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [3:0]  sel = 4'h0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [31:0] rd;
  logic [31:0] wb_q;
  logic        ack;
  logic [15:0] amp = 16'h0;
  logic [15:0] ph = 16'h0;
  logic [7:0]  uo = 8'h33;
  logic [7:0]  din = 8'h00;
  logic [7:0]  vin = 8'h00;
  logic [31:0] cycles = 32'h0;
  meas_t       meas;
  inv_req_t    inv_req;
  logic        start;
  logic        trip;
  logic        seen;
  int          n;
  int          fails = 0;
  int          compares = 0;
  always #12.5 clk = ~clk;
  // short tick and force timeout keep the run small
  earth_fault_stage_logic #(.MS_CYCLES(4), .FORCE_MS(5)) u_dut (
    .clock_i(clk), .reset_n_i(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_q), .wb_ack_o(ack),
    .meas_i(meas), .stamp_i({32'h0, cycles}), .set_group_i(2'h2), .digital_in_i(din),
    .virtual_in_i(vin), .inverse_time_ms_i(20'h3), .inv_req_o(inv_req),
    .start_o(start), .trip_o(trip));
  front_end_model u_fe (.clock_i(clk), .io_amp_i(amp), .ph_amp_i(ph), .uo_i(uo), .meas_o(meas));
  task automatic stop_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 32'h1;
    if (cycles == 32'd20000) begin
      fails++;
      stop_test();
    end
  end
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  // classic cycle: hold until ack seen at an edge, then release
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hf;
    do @(posedge clk); while (ack !== 1'b1);
    rd = wb_q;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wait_trip();
    n = 0;
    while (trip !== 1'b1 && n < 60) begin
      tick(1);
      n++;
    end
  endtask
  task automatic pulse(input int on, input int off);
    amp <= 16'h140;
    repeat (on) begin
      @(posedge clk);
      seen |= trip;
    end
    amp <= 16'h0;
    repeat (off) begin
      @(posedge clk);
      seen |= trip;
    end
  endtask
  task automatic t_regs();
    logic [7:0]  ra [5] = '{OFS_PICKUP, OFS_UOPICK, OFS_HALF, OFS_OPTIME, 8'h44};
    logic [31:0] rv [5] = '{32'h100, 32'h0a, 32'd88, 32'd100, 32'h0};
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, ra[i], 32'h0);
      chk("reset value", rv[i], rd);
    end
    $display("t_regs done");
  endtask
  task automatic t_trip();
    bus(1'b1, OFS_CTRL, 32'h2);
    bus(1'b1, OFS_OPTIME, 32'd5);
    amp <= 16'h100;
    tick(6);
    chk("start at pickup", 0, start);
    amp <= 16'h101;
    wait_trip();
    chk("trip delay", 1, n >= 20 && n <= 36);
    chk("start", 1, start);
    amp <= 16'h0;
    tick(6);
    bus(1'b1, OFS_RSEL, 32'h0);
    bus(1'b0, OFS_REC3, 32'h0);
    chk("record delay", PCT_FULL, rd[7:0]);
    chk("record group", 3, rd[31:29]);
    bus(1'b0, OFS_COUNT, 32'h0);
    chk("counters", 32'h0001_0001, rd);
    bus(1'b1, OFS_COUNT, 32'h0);
    bus(1'b0, OFS_COUNT, 32'h0);
    chk("counters cleared", 0, rd);
    $display("t_trip done");
  endtask
  task automatic t_intr();
    bus(1'b1, OFS_INTRMT, 32'd10);
    seen = 1'b0;
    pulse(16, 8);
    pulse(16, 60);
    chk("intermittent trip", 1, seen);
    bus(1'b1, OFS_INTRMT, 32'd0);
    seen = 1'b0;
    pulse(16, 24);
    pulse(16, 20);
    chk("count cleared", 0, seen);
    bus(1'b0, OFS_REC3, 32'h0);
    chk("partial delay", 1, rd[7:0] < PCT_FULL);
    $display("t_intr done");
  endtask
  task automatic t_inv();
    bus(1'b1, OFS_KMULT, 32'h200);
    bus(1'b1, OFS_OPTIME, 32'd50);
    bus(1'b1, OFS_CTRL, 32'h6);
    bus(1'b1, OFS_CURVE, 32'h21);
    amp <= 16'h180;
    tick(4);
    chk("curve select", 32'h21, {inv_req.curve_type, inv_req.family});
    chk("multiplier", 16'h200, inv_req.k_mult);
    chk("curve current", 16'h180, inv_req.current);
    wait_trip();
    chk("inverse trip", 1, n < 40);
    amp <= 16'h0;
    tick(20);
    $display("t_inv done");
  endtask
  task automatic t_input();
    bus(1'b1, OFS_CTRL, 32'ha);
    ph <= 16'h40;
    tick(6);
    chk("phase sum start", 1, start);
    bus(1'b0, OFS_SELVAL, 32'h0);
    chk("phase sum", 32'h120, rd);
    bus(1'b1, OFS_CTRL, 32'h2);
    tick(6);
    chk("measured quiet", 0, start);
    ph <= 16'h0;
    $display("t_input done");
  endtask
  task automatic t_mode();
    logic [31:0] cv [7] = '{32'h1, 32'h2, 32'h0, 32'h20, 32'hc0, 32'h40, 32'h60};
    logic [1:0]  sv [7] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h2, 2'h1, 2'h2};
    din <= 8'h02;
    vin <= 8'h01;
    for (int i = 0; i < 7; i++) begin
      bus(1'b1, OFS_CTRL, cv[i]);
      tick(3);
      bus(1'b0, OFS_STATUS, 32'h0);
      chk("submode", sv[i], rd[3:2]);
      chk("voltage percent", uo, rd[15:8]);
    end
    $display("t_mode done");
  endtask
  task automatic t_sector();
    bus(1'b1, OFS_CTRL, 32'h1);
    bus(1'b1, OFS_OFFSET, 32'd89);
    amp <= 16'h140;
    tick(6);
    chk("outside sector", 0, start);
    bus(1'b1, OFS_OFFSET, 32'd88);
    tick(3);
    chk("inside sector", 1, start);
    amp <= 16'h0;
    tick(20);
    $display("t_sector done");
  endtask
  task automatic t_force();
    bus(1'b1, OFS_CTRL, 32'h2);
    bus(1'b1, OFS_STATUS, 32'h1);
    tick(3);
    chk("unforced write", 0, start);
    bus(1'b1, OFS_CTRL, 32'h402);
    bus(1'b1, OFS_STATUS, 32'h1);
    tick(3);
    chk("forced start", 1, start);
    tick(40);
    bus(1'b0, OFS_CTRL, 32'h0);
    chk("force timeout", 32'h2, rd);
    $display("t_force done");
  endtask
  initial begin
    tick(20);
    reset_n <= 1'b1;
    t_regs();
    t_trip();
    t_intr();
    t_inv();
    t_input();
    t_mode();
    t_sector();
    t_force();
    stop_test();
  end
endmodule
`default_nettype wire
